// [verilog/tmr_cc_pkg.sv]
package tmr_cc_pkg;
  // =====================================================
  // register map, byte addresses
  localparam logic [11:0] OFF_CC3  = 12'h03c;
  localparam logic [11:0] OFF_CC4  = 12'h040;
  localparam logic [11:0] OFF_BKDT = 12'h044;
  localparam logic [11:0] OFF_DUP3 = 12'h060;
  localparam logic [11:0] OFF_DUP4 = 12'h064;
  // =====================================================
  // break_deadtime_ctrl fields
  localparam int MOE_BIT  = 15;
  localparam int AOE_BIT  = 14;
  localparam int BKP_BIT  = 13;
  localparam int BREAK_ENABLE_BIT = 12;
  localparam int RUN_OFFSTATE_SELECT_BIT = 11;
  localparam int IDLE_OFFSTATE_SELECT_BIT = 10;
  localparam int DT_LSB   = 0;
  localparam int DT_W     = 8;
  // lock field not built, reads zero
  localparam logic [15:0] BKDT_WMASK = 16'hfcff;
  // =====================================================
  // reset values
  localparam logic [15:0] CC_RST   = 16'h0000;
  localparam logic [15:0] BKDT_RST = 16'h0000;
endpackage

// [verilog/cc_chan_if.sv]
`timescale 1ns/1ps
interface cc_chan_if;
  logic        wr_en;
  logic [15:0] wdata;
  logic        is_output;
  logic        preload_en;
  logic        update;
  logic        capture;
  logic [15:0] count;
  logic [15:0] value;
  logic        cmp_out;
  modport ctrl (output wr_en, wdata, is_output, preload_en, update,
                capture, count, input value, cmp_out);
  modport chan (input wr_en, wdata, is_output, preload_en, update,
                capture, count, output value, cmp_out);
endinterface

// [verilog/cc_channel.sv]
`timescale 1ns/1ps
module cc_channel (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control side
  cc_chan_if.chan  ch
);
  // checks below share one clock and reset
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  typedef struct packed {
    logic [15:0] preload;
    logic [15:0] active;
    logic        cmp;
  } chan_st_t;
  chan_st_t st_ff;
  chan_st_t nxt_st;

  // =====================================================
  // preload, transfer, capture and compare
  always_comb begin
    nxt_st = st_ff;
    if (ch.is_output) begin
      if (ch.update) nxt_st.active = st_ff.preload; // [RL3]
      if (ch.wr_en) begin
        nxt_st.preload = ch.wdata;
        if (!ch.preload_en) nxt_st.active = ch.wdata; // [RL2]
      end
    end else if (ch.capture) begin
      nxt_st.preload = ch.count; // [RL4] [RL5]
      nxt_st.active  = ch.count;
    end
    // reference high while count below compare value
    nxt_st.cmp = ch.is_output && (ch.count < st_ff.active); // [RL1]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_ff <= '{preload: tmr_cc_pkg::CC_RST,
                             active: tmr_cc_pkg::CC_RST, cmp: 1'b0};
    else st_ff <= nxt_st;
  end

  assign ch.value   = st_ff.preload;
  assign ch.cmp_out = st_ff.cmp;

  // =====================================================
  // checks
  property p_direct_load;
    ch.is_output && ch.wr_en && !ch.preload_en
      |=> st_ff.active == $past(ch.wdata);
  endproperty
  a_direct_load: assert property (p_direct_load) // [RL2]
    else $error("direct write did not reach active");
  property p_preload_hold;
    ch.is_output && ch.preload_en && !ch.update
      |=> st_ff.active == $past(st_ff.active);
  endproperty
  a_preload_hold: assert property (p_preload_hold) // [RL3]
    else $error("preloaded value moved without update");
  property p_capture;
    !ch.is_output && ch.capture |=> ch.value == $past(ch.count);
  endproperty
  a_capture: assert property (p_capture) // [RL4]
    else $error("capture did not latch the count");
  property p_compare;
    ch.is_output |=> ch.cmp_out == ($past(ch.count) < $past(st_ff.active));
  endproperty
  a_compare: assert property (p_compare) // [RL1]
    else $error("compare output wrong");
endmodule

// [verilog/out_stage.sv]
`timescale 1ns/1ps
module out_stage #(
  parameter bit HAS_COMPL = 1'b1
) (
  // steering
  input  wire logic       moe,
  input  wire logic       run_offstate_select,
  input  wire logic       idle_offstate_select,
  input  wire logic [1:0] is_output,
  input  wire logic [1:0] ref_lvl,
  // per channel enables and idle levels
  input  wire logic [1:0] ccen,
  input  wire logic [1:0] ccnen,
  input  wire logic [1:0] idle,
  input  wire logic [1:0] idle_n,
  // pins
  output logic      [1:0] out,
  output logic      [1:0] out_en,
  output logic      [1:0] outn,
  output logic      [1:0] outn_en
);
  // =====================================================
  // output state table, no dead-time insertion
  always_comb begin
    out = 2'h0; out_en = 2'h0; outn = 2'h0; outn_en = 2'h0;
    for (int i = 0; i < 2; i++) begin
      if (!is_output[i]) begin
        out_en[i] = 1'b0;
      end else if (moe) begin
        // off-state while running needs run_offstate_select and a sibling enable
        if (ccen[i]) begin
          out[i] = ref_lvl[i]; out_en[i] = 1'b1; // [RL10]
        end else if (run_offstate_select && ccnen[i]) begin
          out_en[i] = 1'b1; // [RL15]
        end
        if (HAS_COMPL && ccnen[i]) begin
          outn[i] = ~ref_lvl[i]; outn_en[i] = 1'b1; // [RL10]
        end else if (HAS_COMPL && run_offstate_select && ccen[i]) begin
          outn_en[i] = 1'b1; // [RL15]
        end
      end else if (idle_offstate_select && (ccen[i] || ccnen[i])) begin
        out[i] = idle[i]; out_en[i] = 1'b1; // [RL17]
        outn[i] = HAS_COMPL & idle_n[i];
        outn_en[i] = HAS_COMPL;
      end
    end
  end
endmodule

// [verilog/tmr_ch34_cmp_brk.sv]
`timescale 1ns/1ps
// Operation
// RL1 - An output channel compares its 16-bit value with the count.
// RL2 - Without preload a compare write reaches the active value at once.
// RL3 - With preload a written value moves to active on update only.
// RL4 - Channel 3 in input mode holds the count at its last capture.
// RL5 - Channel 4 in input mode holds the count at its last capture.
// RL6 - Compare and duplicate registers are read-only in input mode.
// RL7 - Registers sit at 0x3C, 0x40, 0x44 and reset to zero.
// RL8 - Software sets every lockable break field in its first write.
// RL9 - The main output enable drops at once when break is active.
// RL10 - Main output enable off idles outputs, on passes enabled ones.
// RL11 - Auto enable lets update set main output enable without break.
// RL12 - Break polarity picks low or high as the active break level.
// RL13 - Break enable gates the break pin and clock failure events.
// RL14 - Break polarity and enable take effect one cycle after write.
// RL15 - Run off-state select drives inactive outputs when running.
// RL16 - Without complementary outputs the run select is not built.
// RL17 - Idle off-state select drives idle levels when not running.
module tmr_ch34_cmp_brk #(
  parameter bit HAS_COMPL = 1'b1
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // timer core
  input  wire logic [15:0] timer_count,
  input  wire logic        update_event,
  input  wire logic        capture_event_ch3,
  input  wire logic        capture_event_ch4,
  input  wire logic        ch3_is_output,
  input  wire logic        ch4_is_output,
  input  wire logic        preload_en_ch3,
  input  wire logic        preload_en_ch4,
  // channel enables and idle levels, index 0 is ch3
  input  wire logic [1:0]  channel_out_enable,
  input  wire logic [1:0]  channel_compl_out_enable,
  input  wire logic [1:0]  idle_level,
  input  wire logic [1:0]  idle_compl_level,
  // break sources
  input  wire logic        break_pin,
  input  wire logic        clock_security_failure,
  // outputs
  output logic             compare_out_ch3,
  output logic             compare_out_ch4,
  output logic             main_output_enable,
  output logic [1:0]       channel_output,
  output logic [1:0]       channel_output_en,
  output logic [1:0]       channel_compl_output,
  output logic [1:0]       channel_compl_output_en
);
  // checks below share one clock and reset
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  typedef struct packed {
    logic [15:0] bkdt;
    logic        bkp_eff;
    logic        break_enable_eff;
    logic [15:0] dup3;
    logic [15:0] dup4;
    logic [31:0] rdata;
    logic        err;
  } top_st_t;

  top_st_t st_ff;
  top_st_t nxt_st;

  cc_chan_if ch3_if ();
  cc_chan_if ch4_if ();

  logic        setup;
  logic        wr_acc;
  logic        brk_active;
  logic        wr_bkdt;
  logic [15:0] wmask;

  // zero-extends a 16-bit register onto the bus
  function automatic logic [31:0] word_of(input logic [15:0] v);
    return {16'h0000, v};
  endfunction

  // ensures a decoded offset is one of ours
  function automatic logic mapped(input logic [11:0] a);
    return a == tmr_cc_pkg::OFF_CC3 || a == tmr_cc_pkg::OFF_CC4 ||
           a == tmr_cc_pkg::OFF_BKDT || a == tmr_cc_pkg::OFF_DUP3 ||
           a == tmr_cc_pkg::OFF_DUP4;
  endfunction

  // =====================================================
  // bus phases; zero wait states
  assign setup   = psel && !penable;
  assign pready  = psel && penable;
  assign wr_acc  = psel && penable && pwrite;
  assign wr_bkdt = wr_acc && paddr == tmr_cc_pkg::OFF_BKDT; // [RL7]
  assign prdata  = st_ff.rdata;
  assign pslverr = pready && st_ff.err;

  // run_offstate_select does not exist without complementary outputs
  assign wmask = HAS_COMPL ? tmr_cc_pkg::BKDT_WMASK
               : (tmr_cc_pkg::BKDT_WMASK &
                  ~(16'h0001 << tmr_cc_pkg::RUN_OFFSTATE_SELECT_BIT)); // [RL16]

  // =====================================================
  // break detect, uses the delayed polarity and enable
  // combinational so outputs fall with no clock edge
  assign brk_active = st_ff.break_enable_eff &&
                      ((break_pin == st_ff.bkp_eff) ||
                       clock_security_failure); // [RL12] [RL13]

  // =====================================================
  // channel hookups, writes blocked in input mode
  assign ch3_if.wr_en      = wr_acc && paddr == tmr_cc_pkg::OFF_CC3 &&
                             ch3_is_output; // [RL6]
  assign ch3_if.wdata      = pwdata[15:0];
  assign ch3_if.is_output  = ch3_is_output;
  assign ch3_if.preload_en = preload_en_ch3;
  assign ch3_if.update     = update_event;
  assign ch3_if.capture    = capture_event_ch3;
  assign ch3_if.count      = timer_count;
  assign ch4_if.wr_en      = wr_acc && paddr == tmr_cc_pkg::OFF_CC4 &&
                             ch4_is_output; // [RL6]
  assign ch4_if.wdata      = pwdata[15:0];
  assign ch4_if.is_output  = ch4_is_output;
  assign ch4_if.preload_en = preload_en_ch4;
  assign ch4_if.update     = update_event;
  assign ch4_if.capture    = capture_event_ch4;
  assign ch4_if.count      = timer_count;

  cc_channel u_ch3 (
    .pclk    (pclk),
    .presetn (presetn),
    .ch      (ch3_if.chan)
  );

  cc_channel u_ch4 (
    .pclk    (pclk),
    .presetn (presetn),
    .ch      (ch4_if.chan)
  );

  assign compare_out_ch3 = ch3_if.cmp_out;
  assign compare_out_ch4 = ch4_if.cmp_out;

  // =====================================================
  // next state: registers, main enable, read data
  always_comb begin
    nxt_st = st_ff;
    // polarity and enable follow the stored bits a cycle late
    nxt_st.bkp_eff  = st_ff.bkdt[tmr_cc_pkg::BKP_BIT]; // [RL14]
    nxt_st.break_enable_eff = st_ff.bkdt[tmr_cc_pkg::BREAK_ENABLE_BIT]; // [RL14]
    if (wr_bkdt) nxt_st.bkdt = pwdata[15:0] & wmask;
    if (wr_acc && paddr == tmr_cc_pkg::OFF_DUP3 && ch3_is_output)
      nxt_st.dup3 = pwdata[15:0]; // [RL6]
    if (wr_acc && paddr == tmr_cc_pkg::OFF_DUP4 && ch4_is_output)
      nxt_st.dup4 = pwdata[15:0]; // [RL6]
    // hardware set beats a software clear in the same cycle
    if (st_ff.bkdt[tmr_cc_pkg::AOE_BIT] && update_event && !brk_active)
      nxt_st.bkdt[tmr_cc_pkg::MOE_BIT] = 1'b1; // [RL11]
    // break wins over everything
    if (brk_active) nxt_st.bkdt[tmr_cc_pkg::MOE_BIT] = 1'b0; // [RL9]
    // read data sampled in setup, held through the access cycle
    if (setup) begin
      nxt_st.err = !mapped(paddr);
      case (paddr)
        tmr_cc_pkg::OFF_CC3:  nxt_st.rdata = word_of(ch3_if.value);
        tmr_cc_pkg::OFF_CC4:  nxt_st.rdata = word_of(ch4_if.value);
        tmr_cc_pkg::OFF_BKDT: nxt_st.rdata = word_of(st_ff.bkdt);
        tmr_cc_pkg::OFF_DUP3: nxt_st.rdata = word_of(st_ff.dup3);
        tmr_cc_pkg::OFF_DUP4: nxt_st.rdata = word_of(st_ff.dup4);
        default:              nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{bkdt: tmr_cc_pkg::BKDT_RST, bkp_eff: 1'b0,
                 break_enable_eff: 1'b0, dup3: tmr_cc_pkg::CC_RST,
                 dup4: tmr_cc_pkg::CC_RST, rdata: 32'h0000_0000,
                 err: 1'b0}; // [RL7]
    end else begin
      st_ff <= nxt_st;
    end
  end

  // =====================================================
  // main enable seen by the pins, gated with no clock
  assign main_output_enable = st_ff.bkdt[tmr_cc_pkg::MOE_BIT] &&
                              !brk_active; // [RL9]

  out_stage #(
    .HAS_COMPL (HAS_COMPL)
  ) u_out (
    .moe       (main_output_enable),
    .run_offstate_select      (st_ff.bkdt[tmr_cc_pkg::RUN_OFFSTATE_SELECT_BIT]),
    .idle_offstate_select      (st_ff.bkdt[tmr_cc_pkg::IDLE_OFFSTATE_SELECT_BIT]),
    .is_output ({ch4_is_output, ch3_is_output}),
    .ref_lvl   ({ch4_if.cmp_out, ch3_if.cmp_out}),
    .ccen      (channel_out_enable),
    .ccnen     (channel_compl_out_enable),
    .idle      (idle_level),
    .idle_n    (idle_compl_level),
    .out       (channel_output),
    .out_en    (channel_output_en),
    .outn      (channel_compl_output),
    .outn_en   (channel_compl_output_en)
  );

  // =====================================================
  // checks
  property p_brk_kills_moe;
    brk_active |-> !main_output_enable && channel_output_en ==
      ({2{st_ff.bkdt[tmr_cc_pkg::IDLE_OFFSTATE_SELECT_BIT]}} &
       (channel_out_enable | channel_compl_out_enable) &
       {ch4_is_output, ch3_is_output});
  endproperty
  a_brk_kills_moe: assert property (p_brk_kills_moe) // [RL9]
    else $error("break did not drop main enable");

  property p_auto_set;
    st_ff.bkdt[tmr_cc_pkg::AOE_BIT] && update_event && !brk_active
      |=> st_ff.bkdt[tmr_cc_pkg::MOE_BIT];
  endproperty
  a_auto_set: assert property (p_auto_set) // [RL11]
    else $error("update did not set main enable");

  property p_no_auto;
    !st_ff.bkdt[tmr_cc_pkg::AOE_BIT] && !wr_bkdt &&
    !st_ff.bkdt[tmr_cc_pkg::MOE_BIT] |=> !st_ff.bkdt[tmr_cc_pkg::MOE_BIT];
  endproperty
  a_no_auto: assert property (p_no_auto) // [RL11]
    else $error("main enable set without software");

  property p_bk_delay;
    wr_bkdt ##1 !wr_bkdt |=>
      st_ff.bkp_eff == $past(pwdata[tmr_cc_pkg::BKP_BIT], 2) &&
      st_ff.break_enable_eff == $past(pwdata[tmr_cc_pkg::BREAK_ENABLE_BIT], 2);
  endproperty
  a_bk_delay: assert property (p_bk_delay) // [RL14]
    else $error("break settings not one cycle late");

  property p_break_enable_off;
    !st_ff.break_enable_eff |-> !brk_active;
  endproperty
  a_break_enable_off: assert property (p_break_enable_off) // [RL13]
    else $error("disabled break still active");

  property p_pol;
    st_ff.break_enable_eff && !clock_security_failure |->
      brk_active == (break_pin == st_ff.bkp_eff);
  endproperty
  a_pol: assert property (p_pol) // [RL12]
    else $error("break polarity wrong");

  property p_input_ro;
    !ch3_is_output && !capture_event_ch3 ##0 $stable(ch3_is_output)
      |=> ch3_if.value == $past(ch3_if.value);
  endproperty
  a_input_ro: assert property (p_input_ro) // [RL6]
    else $error("input-mode register changed by write");

  property p_run_offstate_select_run;
    main_output_enable && ch3_is_output && HAS_COMPL &&
    st_ff.bkdt[tmr_cc_pkg::RUN_OFFSTATE_SELECT_BIT] && !channel_out_enable[0] &&
    channel_compl_out_enable[0] |-> channel_output_en[0] &&
    !channel_output[0];
  endproperty
  a_run_offstate_select_run: assert property (p_run_offstate_select_run) // [RL15]
    else $error("run off-state not driven");

  property p_no_run_offstate_select;
    !HAS_COMPL |-> !st_ff.bkdt[tmr_cc_pkg::RUN_OFFSTATE_SELECT_BIT];
  endproperty
  a_no_run_offstate_select: assert property (p_no_run_offstate_select) // [RL16]
    else $error("run select exists without compl outputs");

  property p_idle_off;
    !main_output_enable && !st_ff.bkdt[tmr_cc_pkg::IDLE_OFFSTATE_SELECT_BIT]
      |-> channel_output_en == 2'h0 && channel_compl_output_en == 2'h0;
  endproperty
  a_idle_off: assert property (p_idle_off) // [RL17]
    else $error("idle outputs driven with idle_offstate_select clear");

  property p_read_bkdt;
    setup && !pwrite && paddr == tmr_cc_pkg::OFF_BKDT
      |=> prdata == word_of($past(st_ff.bkdt)) && !pslverr;
  endproperty
  a_read_bkdt: assert property (p_read_bkdt) // [RL7]
    else $error("bkdt read at 0x44 wrong");

  property p_unmapped_err;
    setup && !mapped(paddr)
      |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) // [RL7]
    else $error("unmapped access not refused");

  property p_sw_moe;
    wr_bkdt && !brk_active &&
    !(st_ff.bkdt[tmr_cc_pkg::AOE_BIT] && update_event)
      |=> st_ff.bkdt[tmr_cc_pkg::MOE_BIT] ==
          $past(pwdata[tmr_cc_pkg::MOE_BIT]);
  endproperty
  a_sw_moe: assert property (p_sw_moe) // [RL11]
    else $error("software write to main enable lost");

  property p_dup_ro;
    !ch3_is_output && wr_acc && paddr == tmr_cc_pkg::OFF_DUP3
      |=> st_ff.dup3 == $past(st_ff.dup3);
  endproperty
  a_dup_ro: assert property (p_dup_ro) // [RL6]
    else $error("input-mode duplicate register written");

  property p_dup_rw;
    ch3_is_output && wr_acc && paddr == tmr_cc_pkg::OFF_DUP3
      |=> st_ff.dup3 == $past(pwdata[15:0]);
  endproperty
  a_dup_rw: assert property (p_dup_rw) // [RL6]
    else $error("output-mode duplicate write lost");

  property p_run_on;
    main_output_enable && ch3_is_output && channel_out_enable[0]
      |-> channel_output_en[0] && channel_output[0] == compare_out_ch3;
  endproperty
  a_run_on: assert property (p_run_on) // [RL10]
    else $error("running channel output not passed");

  property p_idle_lvl;
    !main_output_enable && st_ff.bkdt[tmr_cc_pkg::IDLE_OFFSTATE_SELECT_BIT] &&
    ch3_is_output && (channel_out_enable[0] || channel_compl_out_enable[0])
      |-> channel_output_en[0] && channel_output[0] == idle_level[0];
  endproperty
  a_idle_lvl: assert property (p_idle_lvl) // [RL17]
    else $error("idle level not driven");

  property p_run_offstate_select_off;
    main_output_enable && HAS_COMPL && ch3_is_output &&
    !st_ff.bkdt[tmr_cc_pkg::RUN_OFFSTATE_SELECT_BIT] && channel_out_enable[0] &&
    !channel_compl_out_enable[0] |-> !channel_compl_output_en[0];
  endproperty
  a_run_offstate_select_off: assert property (p_run_offstate_select_off) // [RL15]
    else $error("run off-state driven with select clear");
endmodule

// [verif/tmr_core_model.sv]
`timescale 1ns/1ps
// =====================================================
// timer core stand-in: free running count, update at wrap
module tmr_core_model #(
  parameter logic [15:0] PERIOD = 16'h0020
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // counter side
  output logic      [15:0] timer_count,
  output logic             update_event
);
  // update marks the last count, so the wrap and reload coincide
  assign update_event = (timer_count == PERIOD - 16'h0001);

  // count wraps at the period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count <= 16'h0000;
    end else if (update_event) begin
      timer_count <= 16'h0000;
    end else begin
      timer_count <= timer_count + 16'h0001;
    end
  end
endmodule

// [verif/tmr_ch34_cmp_brk_test.sv]
`timescale 1ns/1ps
module tmr_ch34_cmp_brk_test;
  // =====================================================
  // stimulus and observed signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, upd;
  logic [15:0] cnt;
  logic        cap3 = 1'b0, cap4 = 1'b0, out3 = 1'b1, out4 = 1'b1;
  logic        pre3 = 1'b0, pre4 = 1'b0, brk = 1'b0, csf = 1'b0;
  logic [1:0]  ccen = 2'b00, ccnen = 2'b00, idl = 2'b00, idln = 2'b00;
  logic        cmp3, cmp4, moe;
  logic [1:0]  o, o_en, on, on_en;
  int          num_errors = 0, n_tests = 0;
  logic [31:0] rd, rd_nc, prdata_nc;
  logic [1:0]  on_en_nc;
  logic        er;

  always #2 pclk = ~pclk;

  tmr_core_model u_core (.pclk(pclk), .presetn(presetn),
    .timer_count(cnt), .update_event(upd));

  tmr_ch34_cmp_brk u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_count(cnt), .update_event(upd), .capture_event_ch3(cap3),
    .capture_event_ch4(cap4), .ch3_is_output(out3), .ch4_is_output(out4),
    .preload_en_ch3(pre3), .preload_en_ch4(pre4),
    .channel_out_enable(ccen), .channel_compl_out_enable(ccnen),
    .idle_level(idl), .idle_compl_level(idln), .break_pin(brk),
    .clock_security_failure(csf), .compare_out_ch3(cmp3),
    .compare_out_ch4(cmp4), .main_output_enable(moe),
    .channel_output(o), .channel_output_en(o_en),
    .channel_compl_output(on), .channel_compl_output_en(on_en));

  // variant without complementary outputs, shares every input
  tmr_ch34_cmp_brk #(.HAS_COMPL(1'b0)) u_dut_nc (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata_nc), .pready(),
    .pslverr(), .timer_count(cnt), .update_event(upd),
    .capture_event_ch3(cap3), .capture_event_ch4(cap4),
    .ch3_is_output(out3), .ch4_is_output(out4), .preload_en_ch3(pre3),
    .preload_en_ch4(pre4), .channel_out_enable(ccen),
    .channel_compl_out_enable(ccnen), .idle_level(idl),
    .idle_compl_level(idln), .break_pin(brk),
    .clock_security_failure(csf), .compare_out_ch3(),
    .compare_out_ch4(), .main_output_enable(), .channel_output(),
    .channel_output_en(), .channel_compl_output(),
    .channel_compl_output_en(on_en_nc));

  // =====================================================
  // shared helpers
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a hang is ended by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    rd_nc = prdata_nc;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wait_upd;
    do begin
      @(posedge pclk);
    end while (upd !== 1'b1);
    #1;
  endtask

  // compare output lags the count by one edge
  task automatic cmp_run(input bit ch, input logic [15:0] v, input int k);
    logic [15:0] c;
    repeat (k) begin
      @(posedge pclk);
      c = cnt;
      #1;
      chk("cmp_out", {31'h0, c < v}, {31'h0, ch ? cmp4 : cmp3});
    end
  endtask

  // =====================================================
  // scenarios
  task automatic t_reset;
    apb(0, tmr_cc_pkg::OFF_CC3, 0);  chk("cc3", 0, rd);
    apb(0, tmr_cc_pkg::OFF_CC4, 0);  chk("cc4", 0, rd);
    apb(0, tmr_cc_pkg::OFF_BKDT, 0); chk("bkdt", 0, rd);
    apb(0, 12'h100, 0);              chk("slverr", 1, er);
    // every lockable field set in the first write
    apb(1, tmr_cc_pkg::OFF_BKDT, 32'h0000_b0a5);
    apb(0, tmr_cc_pkg::OFF_BKDT, 0); chk("bkdt", 32'hb0a5, rd);
  endtask

  task automatic t_cmp;
    apb(1, tmr_cc_pkg::OFF_CC3, 32'h0000_0008);
    cmp_run(0, 16'h0008, 40);
    @(posedge pclk);
    pre4 <= 1'b1;
    wait_upd();
    apb(1, tmr_cc_pkg::OFF_CC4, 32'h0000_0010);
    cmp_run(1, 16'h0000, 4);
    wait_upd();
    cmp_run(1, 16'h0010, 40);
  endtask

  task automatic t_cap(input bit ch);
    logic [15:0] c;
    logic [11:0] a;
    logic [11:0] dup;
    a = ch ? tmr_cc_pkg::OFF_CC4 : tmr_cc_pkg::OFF_CC3;
    dup = ch ? tmr_cc_pkg::OFF_DUP4 : tmr_cc_pkg::OFF_DUP3;
    @(posedge pclk);
    if (ch) out4 <= 1'b0; else out3 <= 1'b0;
    repeat (3) @(posedge pclk);
    if (ch) cap4 <= 1'b1; else cap3 <= 1'b1;
    @(posedge pclk);
    c = cnt;
    cap3 <= 1'b0; cap4 <= 1'b0;
    apb(0, a, 0);                chk("capture", {16'h0, c}, rd);
    apb(1, a, 32'h0000_1234);
    apb(0, a, 0);                chk("ro_input", {16'h0, c}, rd);
    apb(1, dup, 32'h0000_5678);
    apb(0, dup, 0);              chk("ro_dup", 0, rd);
    @(posedge pclk);
    out3 <= 1'b1; out4 <= 1'b1;
    apb(1, dup, 32'h0000_5678);
    apb(0, dup, 0);              chk("rw_dup", 32'h5678, rd);
  endtask

  task automatic t_brk;
    apb(1, tmr_cc_pkg::OFF_BKDT, 32'h0000_b000);
    #1 chk("moe", 1, moe);
    @(posedge pclk) brk <= 1'b1;
    #1 chk("moe_async", 0, moe);
    @(posedge pclk) brk <= 1'b0;
    apb(0, tmr_cc_pkg::OFF_BKDT, 0); chk("bkdt", 32'h3000, rd);
    apb(1, tmr_cc_pkg::OFF_BKDT, 32'h0000_b000);
    @(posedge pclk) csf <= 1'b1;
    #1 chk("moe_csf", 0, moe);
    @(posedge pclk) csf <= 1'b0;
    // low level would be active, but break is disabled
    apb(1, tmr_cc_pkg::OFF_BKDT, 32'h0000_8000);
    repeat (3) @(posedge pclk);
    #1 chk("moe_nobrk", 1, moe);
    apb(1, tmr_cc_pkg::OFF_BKDT, 32'h0000_7000);
    #1 chk("moe_sw", 0, moe);
    wait_upd();
    @(posedge pclk);
    #1 chk("moe_auto", 1, moe);
  endtask

  task automatic t_out;
    @(posedge pclk);
    ccen <= 2'b11; idl <= 2'b10; idln <= 2'b01;
    apb(1, tmr_cc_pkg::OFF_BKDT, 32'h0000_0400);
    #1 chk("idle_en", 2'b11, o_en);
    chk("idle_lvl", 2'b10, o);
    chk("idle_n_lvl", 2'b01, on);
    apb(1, tmr_cc_pkg::OFF_BKDT, 32'h0000_0000);
    #1 chk("off_en", 2'b00, o_en);
    apb(1, tmr_cc_pkg::OFF_BKDT, 32'h0000_8800);
    #1 chk("run_en", 2'b11, o_en);
    chk("run_offstate_select_en", 2'b11, on_en);
    apb(0, tmr_cc_pkg::OFF_BKDT, 0); chk("run_offstate_select_rd", 32'h8800, rd);
    chk("run_offstate_select_nc_rd", 32'h8000, rd_nc);
    chk("run_offstate_select_nc_en", 2'b00, on_en_nc);
    // ch3 runs on its complement only, true output parked at 0
    @(posedge pclk);
    ccen <= 2'b10; ccnen <= 2'b01;
    @(posedge pclk);
    #1 chk("run_offstate_select_o_en", 2'b11, o_en);
    chk("run_offstate_select_o_lvl", 1'b0, o[0]);
    @(posedge pclk);
    ccen <= 2'b11; ccnen <= 2'b00;
    apb(1, tmr_cc_pkg::OFF_BKDT, 32'h0000_8000);
    #1 chk("run_offstate_select_off", 2'b00, on_en);
  endtask

  // =====================================================
  // verdict and run control
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cmp();
    t_cap(0);
    t_cap(1);
    t_brk();
    t_out();
    close_out();
  end

  // the scenarios need well under 2000 cycles
  initial begin
    #40000;
    num_errors++;
    close_out();
  end
endmodule
